/* File: core/sir_stage_routing.sv */
/*
  Stage input routing register bank: twelve stage copies of two 16-bit
  routing words, plus decode of the selected stage into switch controls.
  Assumes the serial register port logic and the conversion sequencer sit
  on the same clock and present one-cycle read/write strobes.
*/
// Functional notes
// - Twelve independent stage copies of both routing words.
// - Low word: seven 2-bit route fields, inputs 0..6, bits 1:0 to 13:12.
// - High word: six 2-bit route fields, inputs 7..12, bits 1:0 to 11:10.
// - Route code 00 leaves the input off both converter inputs.
// - Route code 01 ties the input to the negative converter input.
// - Route code 10 ties the input to the positive converter input.
// - Route code 11 ties the input to bias; host uses it for unused inputs.
// - High word bits 13:12 select measurement type; host never writes 00.
// - Measurement type 11 selects differential measurement.
// - High word bit 14 set disables the negative front-end offset path.
// - High word bit 15 set disables the positive front-end offset path.
// - Stage zero words at 0x080/0x081; each stage eight words higher.
`default_nettype none
module sir_stage_routing #(
  parameter int NSTAGE = sir_pkg::NUM_STAGES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [sir_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic [sir_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_rd,
  output logic [sir_pkg::DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_hit,
  input wire logic [sir_pkg::STAGE_W-1:0] i_stage,
  output logic [sir_pkg::NUM_INPUTS-1:0] o_pos_sel,
  output logic [sir_pkg::NUM_INPUTS-1:0] o_neg_sel,
  output logic [sir_pkg::NUM_INPUTS-1:0] o_bias_sel,
  output logic [1:0] o_meas_type,
  output logic o_diff_mode,
  output logic o_neg_offset_en,
  output logic o_pos_offset_en
);
  import sir_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NSTAGE-1:0][DATA_W-1:0] low_word;
    logic [NSTAGE-1:0][DATA_W-1:0] high_word;
    logic [NUM_INPUTS-1:0] pos_sel;
    logic [NUM_INPUTS-1:0] neg_sel;
    logic [NUM_INPUTS-1:0] bias_sel;
    logic [1:0] meas_type;
    logic diff_mode;
    logic neg_offset_en;
    logic pos_offset_en;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic hit;
  } sir_state_t;

  sir_state_t state_ff;
  sir_state_t nxt_state;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Returns {hit, is_high_word, stage}; gaps inside a stage block miss
  function automatic logic [STAGE_W+1:0] sir_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    logic ok;
    rel = a - BASE_ADDR;
    ok = (a >= BASE_ADDR) && ((rel >> STRIDE_SHIFT) < ADDR_W'(NSTAGE))
      && (rel[STRIDE_SHIFT-1:1] == '0);
    return {ok, rel[0], rel[STAGE_W+STRIDE_SHIFT-1:STRIDE_SHIFT]};
  endfunction

  logic [STAGE_W+1:0] dec;
  logic stage_ok;
  logic [DATA_W-1:0] cur_low;
  logic [DATA_W-1:0] cur_high;

  assign dec = sir_decode(i_addr);
  assign stage_ok = (i_stage < STAGE_W'(NSTAGE));
  assign cur_low = stage_ok ? state_ff.low_word[i_stage] : '0;
  assign cur_high = stage_ok ? state_ff.high_word[i_stage] : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] route;
    route = ROUTE_NONE;
    nxt_state = state_ff;
    // Routing words keep their contents through reset: they have no defined value
    if (i_wr && dec[STAGE_W+1]) begin
      if (dec[STAGE_W]) begin
        nxt_state.high_word[dec[STAGE_W-1:0]] = i_wdata;
      end else begin
        nxt_state.low_word[dec[STAGE_W-1:0]] = i_wdata & LOW_USED_MASK;
      end
    end
    // Read returns the stored word; a write in the same cycle is not yet seen
    nxt_state.rvalid = i_rd;
    nxt_state.hit = i_rd && dec[STAGE_W+1];
    nxt_state.rdata = '0;
    if (i_rd && dec[STAGE_W+1]) begin
      nxt_state.rdata = dec[STAGE_W] ? state_ff.high_word[dec[STAGE_W-1:0]]
                                     : state_ff.low_word[dec[STAGE_W-1:0]];
    end
    // Switch matrix controls for the stage the sequencer selects
    for (int k = 0; k < NUM_INPUTS; k++) begin
      if (k < LOW_INPUTS) begin
        route = cur_low[ROUTE_W*k +: ROUTE_W];
      end else begin
        route = cur_high[ROUTE_W*(k-LOW_INPUTS) +: ROUTE_W];
      end
      nxt_state.pos_sel[k] = (route == ROUTE_POS);
      nxt_state.neg_sel[k] = (route == ROUTE_NEG);
      nxt_state.bias_sel[k] = (route == ROUTE_BIAS);
    end
    nxt_state.meas_type = cur_high[MTYPE_LSB +: 2];
    nxt_state.diff_mode = (cur_high[MTYPE_LSB +: 2] == MTYPE_DIFF);
    // Offset paths enabled by a zero bit; an absent stage keeps both off
    nxt_state.neg_offset_en = stage_ok && !cur_high[NEG_OFF_BIT];
    nxt_state.pos_offset_en = stage_ok && !cur_high[POS_OFF_BIT];
    if (i_rst) begin
      nxt_state.pos_sel = '0;
      nxt_state.neg_sel = '0;
      nxt_state.bias_sel = '0;
      nxt_state.meas_type = MTYPE_ILLEGAL;
      nxt_state.diff_mode = 1'b0;
      nxt_state.neg_offset_en = 1'b0;
      nxt_state.pos_offset_en = 1'b0;
      nxt_state.rdata = '0;
      nxt_state.rvalid = 1'b0;
      nxt_state.hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    state_ff <= nxt_state;
  end

  assign o_rdata = state_ff.rdata;
  assign o_rvalid = state_ff.rvalid;
  assign o_hit = state_ff.hit;
  assign o_pos_sel = state_ff.pos_sel;
  assign o_neg_sel = state_ff.neg_sel;
  assign o_bias_sel = state_ff.bias_sel;
  assign o_meas_type = state_ff.meas_type;
  assign o_diff_mode = state_ff.diff_mode;
  assign o_neg_offset_en = state_ff.neg_offset_en;
  assign o_pos_offset_en = state_ff.pos_offset_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  route_none_a:
    assert property (stage_ok && cur_low[1:0] == ROUTE_NONE |=> !o_pos_sel[0] && !o_neg_sel[0] && !o_bias_sel[0])
      else $error("unconnected input reached a converter node");
  route_neg_a:
    assert property (stage_ok && cur_high[1:0] == ROUTE_NEG |=> o_neg_sel[7] && !o_pos_sel[7])
      else $error("negative route not applied");
  route_pos_a:
    assert property (stage_ok && cur_low[13:12] == ROUTE_POS |=> o_pos_sel[6] && !o_bias_sel[6])
      else $error("positive route not applied");
  route_bias_a:
    assert property (stage_ok && cur_high[11:10] == ROUTE_BIAS |=> o_bias_sel[12] && !o_neg_sel[12])
      else $error("bias route not applied");
  diff_mode_a:
    assert property (o_diff_mode |-> o_meas_type == MTYPE_DIFF && $past(cur_high[13:12]) == MTYPE_DIFF)
      else $error("differential mode without its code");
  neg_offset_a:
    assert property (stage_ok |=> o_neg_offset_en == !$past(cur_high[14]))
      else $error("negative offset gate wrong");
  pos_offset_a:
    assert property (stage_ok |=> o_pos_offset_en == !$past(cur_high[15]))
      else $error("positive offset gate wrong");
  low_unused_a:
    assert property (i_rd && dec[STAGE_W+1] && !dec[STAGE_W] |=> o_hit && o_rdata[15:14] == 2'h0)
      else $error("unused low-word bits read nonzero");
  stage1_rw_a:
    assert property (i_wr && i_addr == BASE_ADDR + STAGE_STRIDE + HIGH_WORD_OFS ##1
                     i_rd && !i_wr && i_addr == BASE_ADDR + STAGE_STRIDE + HIGH_WORD_OFS
                     |=> o_rvalid && o_hit && o_rdata == $past(i_wdata, 2))
      else $error("stage one high word lost");
  absent_stage_a:
    assert property (!stage_ok |=> o_pos_sel == '0 && o_neg_sel == '0 && !o_pos_offset_en)
      else $error("absent stage drove the matrix");
  route_open_a:
    assert property (stage_ok && cur_high[11:10] == ROUTE_NONE
                     |=> !o_pos_sel[12] && !o_neg_sel[12] && !o_bias_sel[12])
      else $error("unconnected high input reached a converter node");
  meas_type_a:
    assert property (stage_ok |=> o_meas_type == $past(cur_high[MTYPE_LSB +: 2]))
      else $error("measurement type not passed on");
  absent_type_a:
    assert property (!stage_ok
                     |=> o_meas_type == MTYPE_ILLEGAL && !o_diff_mode && !o_neg_offset_en && o_bias_sel == '0)
      else $error("absent stage set a measurement type");

  // ----------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------
  read_pulse_a:
    assert property (i_rd |=> o_rvalid)
      else $error("read produced no answer");
  read_miss_a:
    assert property (i_rd && (i_addr < BASE_ADDR || i_addr >= BASE_ADDR + ADDR_W'(NSTAGE) * STAGE_STRIDE)
                     |=> !o_hit && o_rdata == '0)
      else $error("unmapped read returned data");
  // Own empty disable, so the quiet outputs are watched while reset is high
  reset_quiet_a:
    assert property (disable iff (1'b0) i_rst |=> o_pos_sel == '0 && o_neg_sel == '0 && o_bias_sel == '0
                     && o_meas_type == MTYPE_ILLEGAL && !o_diff_mode && !o_neg_offset_en && !o_pos_offset_en
                     && !o_rvalid && !o_hit && o_rdata == '0)
      else $error("outputs active during reset");
endmodule
`default_nettype wire

/* File: core/sir_pkg.sv */
/*
  Constants shared by the stage input routing register bank: address map,
  field layout and the codes of the route and measurement-type fields.
  Assumes a word-addressed internal register port of 10-bit addresses.
*/
`default_nettype none
package sir_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int NUM_STAGES = 12;
  localparam int NUM_INPUTS = 13;
  localparam int STAGE_W = 4;
  // Word address map of the bank
  localparam logic [ADDR_W-1:0] BASE_ADDR = 10'h080;
  localparam int STRIDE_SHIFT = 3;
  localparam logic [ADDR_W-1:0] STAGE_STRIDE = 10'h008;
  localparam logic [ADDR_W-1:0] LOW_WORD_OFS = 10'h000;
  localparam logic [ADDR_W-1:0] HIGH_WORD_OFS = 10'h001;
  // Field layout
  localparam int LOW_INPUTS = 7;
  localparam int ROUTE_W = 2;
  localparam int MTYPE_LSB = 12;
  localparam int NEG_OFF_BIT = 14;
  localparam int POS_OFF_BIT = 15;
  localparam logic [DATA_W-1:0] LOW_USED_MASK = 16'h3fff;
  // Route field codes
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_NEG = 2'h1;
  localparam logic [1:0] ROUTE_POS = 2'h2;
  localparam logic [1:0] ROUTE_BIAS = 2'h3;
  // Measurement-type field codes
  localparam logic [1:0] MTYPE_ILLEGAL = 2'h0;
  localparam logic [1:0] MTYPE_SE_POS = 2'h1;
  localparam logic [1:0] MTYPE_SE_NEG = 2'h2;
  localparam logic [1:0] MTYPE_DIFF = 2'h3;
endpackage
`default_nettype wire

/* File: verification/stage_input_routing_config_test.sv */
/*
  Bench for the stage routing bank: register access over the word port
  and decode of the selected stage into switch controls.
  Assumes sir_pkg and sir_stage_routing are compiled before this file.
*/
`default_nettype none
module stage_input_routing_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sir_pkg::*;
  // ----------------------------------------
  // Signals and device
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  // No stage converts until its words are programmed
  logic [STAGE_W-1:0] i_stage = 4'hc;
  logic [DATA_W-1:0] o_rdata;
  logic o_rvalid, o_hit, o_diff_mode, o_neg_offset_en, o_pos_offset_en;
  logic [NUM_INPUTS-1:0] o_pos_sel, o_neg_sel, o_bias_sel;
  logic [1:0] o_meas_type;
  int err_count = 0;
  int n_checks = 0;
  sir_stage_routing dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_hit(o_hit), .i_stage(i_stage),
    .o_pos_sel(o_pos_sel), .o_neg_sel(o_neg_sel), .o_bias_sel(o_bias_sel), .o_meas_type(o_meas_type),
    .o_diff_mode(o_diff_mode), .o_neg_offset_en(o_neg_offset_en), .o_pos_offset_en(o_pos_offset_en));
  initial forever #5 i_clk = ~i_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1 i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(posedge i_clk);
    #1 i_wr = 1'b0;
  endtask
  // Read answer stands one cycle only, so it is judged right after the taking edge
  task rd(input logic [9:0] a, input logic [15:0] e, input logic h);
    @(posedge i_clk);
    #1 i_rd = 1'b1;
    i_addr = a;
    @(posedge i_clk);
    #1 i_rd = 1'b0;
    cmp({15'h0, o_rvalid}, 16'h1, "rvalid");
    cmp({15'h0, o_hit}, {15'h0, h}, "hit");
    cmp(o_rdata, e, "rdata");
  endtask
  function automatic logic [12:0] sel(input logic [15:0] lo, input logic [15:0] hi, input logic [1:0] c);
    logic [25:0] f;
    f = {hi[11:0], lo[13:0]};
    for (int k = 0; k < 13; k++) sel[k] = (f[2*k +: 2] === c);
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    for (int s = 0; s < 12; s++) begin
      wr(10'h080 + 10'(8 * s), 16'hf05a ^ 16'(s << 8));
      wr(10'h081 + 10'(8 * s), 16'ha5c0 + 16'(s));
    end
    // Written neighbour slot must not alias onto a routing word
    wr(10'h082, 16'h1234);
    for (int s = 0; s < 12; s++) begin
      rd(10'h080 + 10'(8 * s), (16'hf05a ^ 16'(s << 8)) & 16'h3fff, 1'b1);
      rd(10'h081 + 10'(8 * s), 16'ha5c0 + 16'(s), 1'b1);
    end
    rd(10'h082, 16'h0, 1'b0);
    rd(10'h07f, 16'h0, 1'b0);
    rd(10'h0e0, 16'h0, 1'b0);
    $display("test regs done");
  endtask
  // Switch controls expected of a programmed stage, from the field layout
  task check_stage(input logic [15:0] lo, input logic [15:0] hi);
    cmp(16'(o_pos_sel), 16'(sel(lo, hi, 2'h2)), "pos sel");
    cmp(16'(o_neg_sel), 16'(sel(lo, hi, 2'h1)), "neg sel");
    cmp(16'(o_bias_sel), 16'(sel(lo, hi, 2'h3)), "bias sel");
    cmp(16'(o_pos_sel | o_neg_sel | o_bias_sel), {3'h0, ~sel(lo, hi, 2'h0)}, "open inputs");
    cmp(16'(o_meas_type), 16'(hi[13:12]), "meas type");
    cmp(16'(o_diff_mode), 16'(hi[13:12] == 2'h3), "diff");
    cmp(16'(o_neg_offset_en), 16'(!hi[14]), "neg offset");
    cmp(16'(o_pos_offset_en), 16'(!hi[15]), "pos offset");
  endtask
  // Write then read back to back, with one read meeting a write to the same word
  task t_b2b;
    @(posedge i_clk);
    #1 i_wr = 1'b1;
    i_addr = 10'h089;
    i_wdata = 16'h3a5c;
    @(posedge i_clk);
    #1 i_rd = 1'b1;
    i_wdata = 16'hd3a6;
    @(posedge i_clk);
    #1 i_wr = 1'b0;
    cmp({15'h0, o_rvalid}, 16'h1, "b2b rvalid");
    cmp({15'h0, o_hit}, 16'h1, "b2b hit");
    cmp(o_rdata, 16'h3a5c, "read beside write");
    @(posedge i_clk);
    #1 i_rd = 1'b0;
    cmp({15'h0, o_hit}, 16'h1, "b2b second hit");
    cmp(o_rdata, 16'hd3a6, "read after write");
    $display("test b2b done");
  endtask
  task t_route(input logic [15:0] lo, input logic [15:0] hi);
    wr(10'h098, lo);
    wr(10'h099, hi);
    @(posedge i_clk);
    #1 i_stage = 4'h3;
    repeat (2) @(posedge i_clk);
    #1;
    check_stage(lo, hi);
    i_stage = 4'hc;
    repeat (2) @(posedge i_clk);
    #1;
    cmp(16'(o_pos_sel | o_neg_sel | o_bias_sel), 16'h0, "idle sel");
    cmp(16'(o_pos_offset_en | o_neg_offset_en), 16'h0, "idle offset");
    cmp({14'h0, o_meas_type}, 16'h0, "idle meas type");
    cmp({15'h0, o_diff_mode}, 16'h0, "idle diff");
    $display("test route %h done", hi);
  endtask
  // Reset in mid-run: quiet outputs while high, stage 3 back at the first edge after it
  task t_reset;
    @(posedge i_clk);
    #1 i_rst = 1'b1;
    i_stage = 4'h3;
    repeat (2) @(posedge i_clk);
    #1 i_rst = 1'b0;
    cmp(16'(o_pos_sel | o_neg_sel | o_bias_sel), 16'h0, "reset sel");
    cmp({13'h0, o_meas_type, o_diff_mode}, 16'h0, "reset type");
    cmp({14'h0, o_neg_offset_en, o_pos_offset_en}, 16'h0, "reset offset");
    cmp({15'h0, o_rvalid}, 16'h0, "reset rvalid");
    @(posedge i_clk);
    #1;
    check_stage(16'h3f3c, 16'h2ffd);
    rd(10'h098, 16'h3f3c, 1'b1);
    $display("test reset done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_rst = 1'b0;
    t_regs();
    t_b2b();
    // Differential, then one positive input, then one negative input
    t_route(16'h1b1b, 16'h76e4);
    t_route(16'h2fff, 16'h93ff);
    t_route(16'h3f3c, 16'h2ffd);
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
